/* File: src/cm_misc_regs.sv */
// Misc control and status register group of the voice codec
// Operation
// - Override bit forces 256x DAC oversampling
// - Unlocked PLL output gated unless pass bit
// - Softmute-zero bit forces limiter output zero during softmute
// - Notch output held 512 samples unless immediate
// - Short frame detector active when bit4 low
// - Flush bit resets DSP on short frame
// - Threshold codes give 255/253/254/255 MCLK edges
// - Force bit selects 4-wire SPI regardless pin
// - Otherwise pin low 2-wire, high 16-bit SPI
// - Forced SPI: 24-bit writes, 32-bit reads
// - Manual tie bits close reference switches
// - Stage bit: two-stage or three-stage speaker
// - Swing readout returns higher ALC peak-to-peak
// - Peak readout returns larger ALC peak
// - Limiter indicator above 87.5 percent full scale
// - Digital mute status set when gain zero
// - Auto mute status follows automute
// - Noise gate status, ALC gain frozen
// - Speaker supply high flag from comparator
// - Tap select chooses automute observation point
`timescale 1ns/10ps
module cm_misc_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register access from the control bus decoder
    input wire logic reg_wr_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [8:0] reg_wdata_i,
    output logic [8:0] reg_rdata_o,
    // Pins, asynchronous
    input wire logic mode_pin_i,
    input wire logic frame_sync_i,
    input wire logic pll_lock_i,
    input wire logic speaker_supply_cmp_i,
    // Core status and control, same clock
    input wire logic os_rate_sel_i,
    input wire logic softmute_active_i,
    input wire logic notch_en_i,
    input wire logic sample_tick_i,
    input wire logic mclk_tick_i,
    input wire logic [2:0] pm_tie_i,
    input wire logic alc_on_a_i,
    input wire logic alc_on_b_i,
    input wire logic [8:0] swing_a_i,
    input wire logic [8:0] swing_b_i,
    input wire logic [8:0] peak_a_i,
    input wire logic [8:0] peak_b_i,
    input wire logic [8:0] limiter_level_i,
    input wire logic [8:0] dac_gain_i,
    input wire logic automute_on_i,
    input wire logic noise_gate_low_i,
    // Controls to the core
    output logic dac_os_256x_o,
    output logic pll_vco_en_o,
    output logic limiter_force_zero_o,
    output logic notch_use_o,
    output logic short_frame_o,
    output logic dsp_flush_o,
    output cm_pkg::cm_mode_e ctrl_mode_o,
    output logic [5:0] spi_wr_len_o,
    output logic [5:0] spi_rd_len_o,
    output logic [2:0] ref_tie_close_o,
    output logic speaker_three_stage_o,
    output logic alc_gain_freeze_o,
    output logic automute_tap_select_o
);
    import cm_pkg::*;

    // Whole module state
    typedef struct packed {
        logic [8:0] misc;
        logic [8:0] tie;
        logic tap;
        logic [2:0] mode_sync; // Two sync stages, third is a delayed copy for checking
        logic [1:0] fs_sync;
        logic fs_prev;
        logic [1:0] lock_sync;
        logic [1:0] hv_sync;
        logic notch_prev;
        logic [9:0] notch_cnt;
        logic [8:0] rdata;
        logic os256;
        logic vco_en;
        logic force_zero;
        logic notch_use;
        cm_mode_e mode;
        logic [5:0] wr_len;
        logic [5:0] rd_len;
        logic [2:0] tie_close;
        logic three_stage;
        logic freeze;
        logic short_q;
        logic flush_q;
    } cm_regs_s;

    cm_regs_s st;
    cm_regs_s next_st;
    logic frame_start;
    logic sf_short;
    logic sf_flush;
    logic [8:0] swing_val;
    logic [8:0] peak_val;
    logic [8:0] status_word;

    // Rising edge of the synchronised frame sync, read from the second stage
    assign frame_start = st.fs_sync[1] && !st.fs_prev;

    // Short frame detector
    cm_short_frame u_short_frame (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .frame_start_i(frame_start),
        .mclk_tick_i(mclk_tick_i),
        .short_frame_detect_disable_i(st.misc[CM_B_SF_DISABLE]),
        .flush_on_short_frame_i(st.misc[CM_B_SF_FLUSH]),
        .short_frame_threshold_i(st.misc[CM_B_SF_THR_LO +: 2]),
        .short_frame_o(sf_short),
        .dsp_flush_o(sf_flush)
    );

    // ALC readouts, larger of the two when both inputs are under ALC
    always_comb
    begin
        if (alc_on_a_i && alc_on_b_i)
        begin
            swing_val = (swing_a_i > swing_b_i) ? swing_a_i : swing_b_i;
            peak_val = (peak_a_i > peak_b_i) ? peak_a_i : peak_b_i;
        end
        else if (alc_on_b_i)
        begin
            swing_val = swing_b_i;
            peak_val = peak_b_i;
        end
        else
        begin
            swing_val = swing_a_i;
            peak_val = peak_a_i;
        end
    end

    // Automute control/status word, bits 1, 7 and 8 stay zero
    always_comb
    begin
        status_word = 9'h000;
        status_word[CM_B_LIMIT] = limiter_level_i > CM_LIMIT_LEVEL;
        status_word[CM_B_DIGITAL_MUTE_STATUS] = dac_gain_i == 9'h000;
        status_word[CM_B_AUTO_MUTE_STATUS] = automute_on_i;
        status_word[CM_B_NGATE] = noise_gate_low_i;
        status_word[CM_B_SPEAKER_SUPPLY_HIGH_FLAG] = st.hv_sync[1];
        status_word[CM_B_TAP] = st.tap;
    end

    // Next state
    always_comb
    begin
        next_st = st;
        // Pin synchronisers
        next_st.mode_sync = {st.mode_sync[1:0], mode_pin_i};
        next_st.fs_sync = {st.fs_sync[0], frame_sync_i};
        next_st.fs_prev = st.fs_sync[1];
        next_st.lock_sync = {st.lock_sync[0], pll_lock_i};
        next_st.hv_sync = {st.hv_sync[0], speaker_supply_cmp_i};
        // Register writes, masked so unassigned bits never store
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                CM_ADDR_MISC: next_st.misc = reg_wdata_i & CM_MASK_MISC;
                CM_ADDR_TIEOFF: next_st.tie = reg_wdata_i & CM_MASK_TIEOFF;
                CM_ADDR_AUTO_MUTE_STATUS: next_st.tap = reg_wdata_i[CM_B_TAP];
                // Read-only or unmapped addresses ignore the write
                default: next_st.tap = st.tap;
            endcase
        end
        // Read data follows the address one cycle later
        case (reg_addr_i)
            CM_ADDR_MISC: next_st.rdata = st.misc;
            CM_ADDR_TIEOFF: next_st.rdata = st.tie;
            CM_ADDR_P2P: next_st.rdata = swing_val;
            CM_ADDR_PEAK: next_st.rdata = peak_val;
            CM_ADDR_AUTO_MUTE_STATUS: next_st.rdata = status_word;
            default: next_st.rdata = 9'h000;
        endcase
        // Oversampling override
        next_st.os256 = st.misc[CM_B_OS256] || os_rate_sel_i;
        // VCO output gated while unlocked unless passing is allowed
        next_st.vco_en = st.misc[CM_B_UNLOCK_PASS] || st.lock_sync[1];
        // Exact zero only requested during softmute
        next_st.force_zero = st.misc[CM_B_SOFTZERO] && softmute_active_i;
        // Notch hold-off counts samples from the enable edge
        next_st.notch_prev = notch_en_i;
        if (!notch_en_i || !st.notch_prev)
        begin
            next_st.notch_cnt = 10'h000;
        end
        else if (sample_tick_i && st.notch_cnt != CM_NOTCH_HOLD)
        begin
            next_st.notch_cnt = st.notch_cnt + 10'h001;
        end
        next_st.notch_use = notch_en_i && st.notch_prev
            && (st.misc[CM_B_NOTCH_NOW] || st.notch_cnt == CM_NOTCH_HOLD);
        // Control bus mode, pin taken from the second sync stage
        if (st.misc[CM_B_FORCE_SPI])
        begin
            next_st.mode = CM_SPI_4W;
            next_st.wr_len = CM_LEN_SPI24;
            next_st.rd_len = CM_LEN_SPI32;
        end
        else if (st.mode_sync[1])
        begin
            next_st.mode = CM_SPI16_WO;
            next_st.wr_len = CM_LEN_SPI16;
            next_st.rd_len = CM_LEN_NONE;
        end
        else
        begin
            next_st.mode = CM_TWO_WIRE;
            next_st.wr_len = CM_LEN_NONE;
            next_st.rd_len = CM_LEN_NONE;
        end
        // Reference tie-offs: manual close overrides power management
        next_st.tie_close = st.tie[CM_B_TIE_HIGH:CM_B_TIE_LOW] | pm_tie_i;
        next_st.three_stage = st.tie[CM_B_SPK_STAGE];
        next_st.freeze = noise_gate_low_i;
        next_st.short_q = sf_short;
        next_st.flush_q = sf_flush;
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
            st.misc <= CM_RST_MISC;
            st.tie <= CM_RST_TIEOFF;
            st.tap <= CM_RST_AUTO_MUTE_STATUS[CM_B_TAP];
            st.mode <= CM_TWO_WIRE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign reg_rdata_o = st.rdata;
    assign dac_os_256x_o = st.os256;
    assign pll_vco_en_o = st.vco_en;
    assign limiter_force_zero_o = st.force_zero;
    assign notch_use_o = st.notch_use;
    assign short_frame_o = st.short_q;
    assign dsp_flush_o = st.flush_q;
    assign ctrl_mode_o = st.mode;
    assign spi_wr_len_o = st.wr_len;
    assign spi_rd_len_o = st.rd_len;
    assign ref_tie_close_o = st.tie_close;
    assign speaker_three_stage_o = st.three_stage;
    assign alc_gain_freeze_o = st.freeze;
    assign automute_tap_select_o = st.tap;

    // Notch enabled with delay mode, then held for a stretch
    sequence s_notch_start;
        $rose(notch_en_i) && !st.misc[CM_B_NOTCH_NOW];
    endsequence
    sequence s_notch_blocked;
        !notch_use_o [*8];
    endsequence

    AST_OS256: assert property (@(posedge clk_i) disable iff (!resetn_i)
        st.misc[CM_B_OS256] |=> dac_os_256x_o)
        else $error("override did not force 256x");
    AST_PLL_GATE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!st.misc[CM_B_UNLOCK_PASS] && !st.lock_sync[1]) |=> !pll_vco_en_o)
        else $error("vco passed while unlocked");
    AST_SOFT_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (st.misc[CM_B_SOFTZERO] && softmute_active_i) |=> limiter_force_zero_o)
        else $error("limiter zero not forced");
    AST_NOTCH_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_notch_start ##1 (notch_en_i && !st.misc[CM_B_NOTCH_NOW]) |=> s_notch_blocked)
        else $error("notch output used too early");
    AST_NOTCH_NOW: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (notch_en_i && st.notch_prev && st.misc[CM_B_NOTCH_NOW]) |=> notch_use_o)
        else $error("notch not used immediately");
    AST_FORCE_SPI: assert property (@(posedge clk_i) disable iff (!resetn_i)
        st.misc[CM_B_FORCE_SPI] |=> (ctrl_mode_o == CM_SPI_4W))
        else $error("forced spi mode not taken");
    AST_PIN_MODE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !st.misc[CM_B_FORCE_SPI]
            |=> (ctrl_mode_o == (st.mode_sync[2] ? CM_SPI16_WO : CM_TWO_WIRE)))
        else $error("pin mode not followed");
    AST_SPI_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ctrl_mode_o == CM_SPI_4W)
            |-> (spi_wr_len_o == CM_LEN_SPI24 && spi_rd_len_o == CM_LEN_SPI32))
        else $error("spi word lengths wrong");
    AST_TIE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        st.tie[CM_B_TIE_LOW] |=> ref_tie_close_o[0])
        else $error("manual tie switch not closed");
    AST_DIGITAL_MUTE_STATUS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_addr_i == CM_ADDR_AUTO_MUTE_STATUS && dac_gain_i == 9'h000) |=> reg_rdata_o[CM_B_DIGITAL_MUTE_STATUS])
        else $error("digital mute status not set");
    AST_RESERVED: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_addr_i == CM_ADDR_AUTO_MUTE_STATUS) |=> (reg_rdata_o[8:7] == 2'b00 && !reg_rdata_o[1]))
        else $error("reserved status bits not zero");
endmodule

/* File: src/cm_pkg.sv */
// Constants and types shared by the codec misc control/status register group
package cm_pkg;
    // Register addresses on the control bus
    localparam logic [6:0] CM_ADDR_MISC = 7'h49;
    localparam logic [6:0] CM_ADDR_TIEOFF = 7'h4B;
    localparam logic [6:0] CM_ADDR_P2P = 7'h4C;
    localparam logic [6:0] CM_ADDR_PEAK = 7'h4D;
    localparam logic [6:0] CM_ADDR_AUTO_MUTE_STATUS = 7'h4E;
    // Reset values
    localparam logic [8:0] CM_RST_MISC = 9'h000;
    localparam logic [8:0] CM_RST_TIEOFF = 9'h000;
    localparam logic [8:0] CM_RST_AUTO_MUTE_STATUS = 9'h000;
    // Writable bit masks, unassigned positions are dropped
    localparam logic [8:0] CM_MASK_MISC = 9'h1FF;
    localparam logic [8:0] CM_MASK_TIEOFF = 9'h087;
    localparam logic [8:0] CM_MASK_AUTO_MUTE_STATUS_WR = 9'h040;
    // Misc control field positions
    localparam int CM_B_OS256 = 0;
    localparam int CM_B_UNLOCK_PASS = 1;
    localparam int CM_B_SOFTZERO = 2;
    localparam int CM_B_NOTCH_NOW = 3;
    localparam int CM_B_SF_DISABLE = 4;
    localparam int CM_B_SF_FLUSH = 5;
    localparam int CM_B_SF_THR_LO = 6;
    localparam int CM_B_FORCE_SPI = 8;
    // Tie-off register field positions
    localparam int CM_B_TIE_LOW = 0;
    localparam int CM_B_TIE_HIGH = 2;
    localparam int CM_B_SPK_STAGE = 7;
    // Automute control/status field positions
    localparam int CM_B_LIMIT = 0;
    localparam int CM_B_DIGITAL_MUTE_STATUS = 2;
    localparam int CM_B_AUTO_MUTE_STATUS = 3;
    localparam int CM_B_NGATE = 4;
    localparam int CM_B_SPEAKER_SUPPLY_HIGH_FLAG = 5;
    localparam int CM_B_TAP = 6;
    // Notch hold-off in sample periods
    localparam logic [9:0] CM_NOTCH_HOLD = 10'h200;
    // Short frame thresholds in master clock edges, by code
    localparam logic [8:0] CM_SF_THR_00 = 9'h0FF;
    localparam logic [8:0] CM_SF_THR_01 = 9'h0FD;
    localparam logic [8:0] CM_SF_THR_10 = 9'h0FE;
    localparam logic [8:0] CM_SF_THR_11 = 9'h0FF;
    // Limiter indication: 87.5 percent of a 9-bit full scale (512 * 7 / 8)
    localparam logic [8:0] CM_LIMIT_LEVEL = 9'h1C0;
    // Control bus word lengths in bits
    localparam logic [5:0] CM_LEN_SPI16 = 6'h10;
    localparam logic [5:0] CM_LEN_SPI24 = 6'h18;
    localparam logic [5:0] CM_LEN_SPI32 = 6'h20;
    localparam logic [5:0] CM_LEN_NONE = 6'h00;
    // Control bus operating mode
    typedef enum logic [1:0] {
        CM_TWO_WIRE,
        CM_SPI16_WO,
        CM_SPI_4W
    } cm_mode_e;
endpackage

/* File: src/cm_short_frame.sv */
// Short frame sync detector counting master clock edges between frame starts
`timescale 1ns/10ps
module cm_short_frame (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Frame timing, same clock domain
    input wire logic frame_start_i,
    input wire logic mclk_tick_i,
    // Configuration
    input wire logic short_frame_detect_disable_i,
    input wire logic flush_on_short_frame_i,
    input wire logic [1:0] short_frame_threshold_i,
    // Events
    output logic short_frame_o,
    output logic dsp_flush_o
);
    import cm_pkg::*;

    // Whole module state
    typedef struct packed {
        logic [8:0] cnt;
        logic armed;
        logic short_ev;
        logic flush;
    } cm_sf_s;

    cm_sf_s st;
    cm_sf_s next_st;
    logic [8:0] thr;

    // Threshold decode, two codes share 255
    always_comb
    begin
        case (short_frame_threshold_i)
            2'b01: thr = CM_SF_THR_01;
            2'b10: thr = CM_SF_THR_10;
            2'b11: thr = CM_SF_THR_11;
            default: thr = CM_SF_THR_00;
        endcase
    end

    // Edge counting and frame judgement
    always_comb
    begin
        next_st = st;
        next_st.short_ev = 1'b0;
        next_st.flush = 1'b0;
        // Saturate so long idle gaps never wrap into a false short frame
        if (mclk_tick_i && st.cnt != 9'h1FF)
        begin
            next_st.cnt = st.cnt + 9'h001;
        end
        if (frame_start_i)
        begin
            // First frame after reset has no reference, so it is not judged
            if (st.armed && !short_frame_detect_disable_i && st.cnt < thr)
            begin
                next_st.short_ev = 1'b1;
                next_st.flush = flush_on_short_frame_i;
            end
            next_st.cnt = 9'h000;
            next_st.armed = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign short_frame_o = st.short_ev;
    assign dsp_flush_o = st.flush;

    AST_SF_DISABLED: assert property (@(posedge clk_i) disable iff (!resetn_i)
        short_frame_detect_disable_i |=> !short_frame_o)
        else $error("short frame reported while detector disabled");
    AST_SF_NOFLUSH: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !flush_on_short_frame_i |=> !dsp_flush_o)
        else $error("flush issued while flush disabled");
endmodule

/* File: bench/cm_host_model.sv */
// Host-side model driving the register port of the misc register group
`timescale 1ns/10ps
module cm_host_model (
    // Clock
    input wire logic clk_i,
    // Register port toward the block
    output logic reg_wr_o,
    output logic [6:0] reg_addr_o,
    output logic [8:0] reg_wdata_o,
    input wire logic [8:0] reg_rdata_i
);
    // Quiet port at time zero
    initial
    begin
        reg_wr_o = 1'b0;
        reg_addr_o = 7'h00;
        reg_wdata_o = 9'h000;
    end
    // One-cycle strobe launched off the falling edge
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        // Released data must not keep showing the written word
        reg_wdata_o = ~d;
    endtask
    // Address taken at one rising edge, word valid after it
    task automatic rd(input logic [6:0] a, output logic [8:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the codec misc control and status registers
`timescale 1ns/10ps
module testbench;
    import cm_pkg::*;
    // Clock, reset and register port
    logic clk_i, resetn_i, reg_wr_i;
    logic [6:0] reg_addr_i;
    logic [8:0] reg_wdata_i, reg_rdata_o;
    // Pins and core-side inputs
    logic mode_pin_i, frame_sync_i, pll_lock_i, speaker_supply_cmp_i, os_rate_sel_i;
    logic softmute_active_i, notch_en_i, sample_tick_i, mclk_tick_i, alc_on_a_i, alc_on_b_i;
    logic automute_on_i, noise_gate_low_i;
    logic [2:0] pm_tie_i;
    logic [8:0] swing_a_i, swing_b_i, peak_a_i, peak_b_i, limiter_level_i, dac_gain_i;
    // Block outputs
    logic dac_os_256x_o, pll_vco_en_o, limiter_force_zero_o, notch_use_o, short_frame_o;
    logic dsp_flush_o, speaker_three_stage_o, alc_gain_freeze_o, automute_tap_select_o;
    cm_mode_e ctrl_mode_o;
    logic [5:0] spi_wr_len_o, spi_rd_len_o;
    logic [2:0] ref_tie_close_o;
    // Counters
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    cm_misc_regs dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .mode_pin_i(mode_pin_i),
        .frame_sync_i(frame_sync_i), .pll_lock_i(pll_lock_i),
        .speaker_supply_cmp_i(speaker_supply_cmp_i), .os_rate_sel_i(os_rate_sel_i),
        .softmute_active_i(softmute_active_i), .notch_en_i(notch_en_i),
        .sample_tick_i(sample_tick_i), .mclk_tick_i(mclk_tick_i), .pm_tie_i(pm_tie_i),
        .alc_on_a_i(alc_on_a_i), .alc_on_b_i(alc_on_b_i), .swing_a_i(swing_a_i),
        .swing_b_i(swing_b_i), .peak_a_i(peak_a_i), .peak_b_i(peak_b_i),
        .limiter_level_i(limiter_level_i), .dac_gain_i(dac_gain_i),
        .automute_on_i(automute_on_i), .noise_gate_low_i(noise_gate_low_i),
        .dac_os_256x_o(dac_os_256x_o), .pll_vco_en_o(pll_vco_en_o),
        .limiter_force_zero_o(limiter_force_zero_o), .notch_use_o(notch_use_o),
        .short_frame_o(short_frame_o), .dsp_flush_o(dsp_flush_o), .ctrl_mode_o(ctrl_mode_o),
        .spi_wr_len_o(spi_wr_len_o), .spi_rd_len_o(spi_rd_len_o),
        .ref_tie_close_o(ref_tie_close_o), .speaker_three_stage_o(speaker_three_stage_o),
        .alc_gain_freeze_o(alc_gain_freeze_o), .automute_tap_select_o(automute_tap_select_o)
    );
    cm_host_model host (
        .clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o)
    );

    // 10 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Hang guard, well above the frame and notch runs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Covers the two pin sync stages plus the output register
    task automatic settle;
        repeat (5) @(negedge clk_i);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [8:0] exp);
        logic [8:0] v;
        host.rd(a, v);
        chk(v, exp);
    endtask

    // Mode pin and forcing bit, plus the rate, lock and mute controls
    task automatic t_misc;
        rchk(CM_ADDR_MISC, 9'h000);
        chk(9'(ctrl_mode_o), 9'(CM_TWO_WIRE));
        chk(9'(spi_wr_len_o), 9'h000);
        mode_pin_i = 1'b1;
        settle();
        chk(9'(ctrl_mode_o), 9'(CM_SPI16_WO));
        chk(9'(spi_wr_len_o), 9'h010);
        chk(9'(spi_rd_len_o), 9'h000);
        host.wr(CM_ADDR_MISC, 9'h107);
        mode_pin_i = 1'b0;
        settle();
        chk(9'(ctrl_mode_o), 9'(CM_SPI_4W));
        chk(9'(spi_wr_len_o), 9'h018);
        chk(9'(spi_rd_len_o), 9'h020);
        chk(9'(dac_os_256x_o), 9'h001);
        chk(9'(pll_vco_en_o), 9'h001);
        chk(9'(limiter_force_zero_o), 9'h001);
        rchk(CM_ADDR_MISC, 9'h107);
        // Zero is only forced while softmute runs
        softmute_active_i = 1'b0;
        settle();
        chk(9'(limiter_force_zero_o), 9'h000);
        softmute_active_i = 1'b1;
        host.wr(CM_ADDR_MISC, 9'h000);
        settle();
        chk(9'(dac_os_256x_o), 9'h000);
        chk(9'(pll_vco_en_o), 9'h000);
        chk(9'(limiter_force_zero_o), 9'h000);
        // Separate rate setting and a real lock still act
        os_rate_sel_i = 1'b1;
        pll_lock_i = 1'b1;
        settle();
        chk(9'(dac_os_256x_o), 9'h001);
        chk(9'(pll_vco_en_o), 9'h001);
        os_rate_sel_i = 1'b0;
        pll_lock_i = 1'b0;
    endtask

    // Manual tie bits OR power-management requests; unassigned bits drop
    task automatic t_tieoff;
        host.wr(CM_ADDR_TIEOFF, 9'h1FF);
        settle();
        rchk(CM_ADDR_TIEOFF, 9'h087);
        chk(9'(ref_tie_close_o), 9'h007);
        chk(9'(speaker_three_stage_o), 9'h001);
        host.wr(CM_ADDR_TIEOFF, 9'h000);
        pm_tie_i = 3'h5;
        settle();
        chk(9'(ref_tie_close_o), 9'h005);
        chk(9'(speaker_three_stage_o), 9'h000);
        pm_tie_i = 3'h0;
    endtask

    // Every ALC ownership case; A wins swing, B wins peak when both count
    task automatic t_readout;
        swing_a_i = 9'h123;
        swing_b_i = 9'h0F0;
        peak_a_i = 9'h055;
        peak_b_i = 9'h1AA;
        for (int i = 0; i < 4; i++)
        begin
            {alc_on_a_i, alc_on_b_i} = i[1:0];
            settle();
            rchk(CM_ADDR_P2P, (i == 1) ? 9'h0F0 : 9'h123);
            rchk(CM_ADDR_PEAK, (i == 0 || i == 2) ? 9'h055 : 9'h1AA);
        end
        host.wr(CM_ADDR_P2P, 9'h000);
        rchk(CM_ADDR_P2P, 9'h123);
        rchk(7'h4A, 9'h000);
    endtask

    // One status source at a time so a swapped bit shows; last pass all idle
    task automatic t_status;
        logic [8:0] tab [7] = '{9'h001, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h000};
        for (int k = 0; k < 7; k++)
        begin
            limiter_level_i = (k == 0) ? 9'h1C1 : 9'h1C0;
            dac_gain_i = (k == 1) ? 9'h000 : 9'h001;
            automute_on_i = (k == 2);
            noise_gate_low_i = (k == 3);
            speaker_supply_cmp_i = (k == 4);
            host.wr(CM_ADDR_AUTO_MUTE_STATUS, (k == 5) ? 9'h1FF : 9'h000);
            settle();
            rchk(CM_ADDR_AUTO_MUTE_STATUS, tab[k]);
            chk(9'(alc_gain_freeze_o), (k == 3) ? 9'h001 : 9'h000);
            chk(9'(automute_tap_select_o), (k == 5) ? 9'h001 : 9'h000);
        end
    endtask

    // Hold-off of 512 sample ticks, then the immediate mode
    task automatic t_notch;
        notch_en_i = 1'b1;
        repeat (3) @(negedge clk_i);
        for (int t = 0; t < 513; t++)
        begin
            sample_tick_i = 1'b1;
            @(negedge clk_i);
            sample_tick_i = 1'b0;
            @(negedge clk_i);
            if (t == 510)
                chk(9'(notch_use_o), 9'h000);
        end
        repeat (3) @(negedge clk_i);
        chk(9'(notch_use_o), 9'h001);
        notch_en_i = 1'b0;
        host.wr(CM_ADDR_MISC, 9'h008);
        settle();
        notch_en_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(9'(notch_use_o), 9'h001);
        notch_en_i = 1'b0;
    endtask

    // Exactly n ticks, then a frame start; pulses counted in a window
    task automatic sf_frame(input int n, input logic [8:0] e_short, input logic [8:0] e_fl);
        logic [8:0] ns, nf;
        ns = 9'h000;
        nf = 9'h000;
        mclk_tick_i = 1'b1;
        repeat (n) @(negedge clk_i);
        mclk_tick_i = 1'b0;
        repeat (4) @(negedge clk_i);
        frame_sync_i = 1'b1;
        for (int c = 0; c < 12; c++)
        begin
            @(negedge clk_i);
            if (c == 3)
                frame_sync_i = 1'b0;
            ns = ns + 9'(short_frame_o);
            nf = nf + 9'(dsp_flush_o);
        end
        chk(ns, e_short);
        chk(nf, e_fl);
    endtask
    task automatic t_frame;
        int thr [4] = '{255, 253, 254, 255};
        host.wr(CM_ADDR_MISC, 9'h020);
        // First frame has no reference and is never judged
        sf_frame(10, 9'h000, 9'h000);
        for (int c = 0; c < 4; c++)
        begin
            host.wr(CM_ADDR_MISC, {1'b0, 2'(c), 6'h20});
            sf_frame(thr[c] - 1, 9'h001, 9'h001);
            sf_frame(thr[c], 9'h000, 9'h000);
        end
        host.wr(CM_ADDR_MISC, 9'h000);
        sf_frame(100, 9'h001, 9'h000);
        host.wr(CM_ADDR_MISC, 9'h030);
        sf_frame(100, 9'h000, 9'h000);
    endtask

    // Reset in mid-run returns every writable field to zero
    task automatic t_reset;
        host.wr(CM_ADDR_TIEOFF, 9'h081);
        host.wr(CM_ADDR_AUTO_MUTE_STATUS, 9'h040);
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        settle();
        rchk(CM_ADDR_MISC, 9'h000);
        rchk(CM_ADDR_TIEOFF, 9'h000);
        rchk(CM_ADDR_AUTO_MUTE_STATUS, 9'h000);
        chk(9'(ref_tie_close_o), 9'h000);
        chk(9'(speaker_three_stage_o), 9'h000);
        chk(9'(automute_tap_select_o), 9'h000);
    endtask

    // Main sequence
    initial
    begin
        resetn_i = 1'b0;
        {mode_pin_i, frame_sync_i, pll_lock_i, speaker_supply_cmp_i, os_rate_sel_i} = '0;
        {notch_en_i, sample_tick_i, mclk_tick_i, alc_on_a_i, alc_on_b_i} = '0;
        {automute_on_i, noise_gate_low_i, pm_tie_i} = '0;
        softmute_active_i = 1'b1;
        {swing_a_i, swing_b_i, peak_a_i, peak_b_i, limiter_level_i} = '0;
        dac_gain_i = 9'h001;
        repeat (16) @(negedge clk_i);
        resetn_i = 1'b1;
        settle();
        t_misc();
        t_tieoff();
        t_readout();
        t_status();
        t_notch();
        t_frame();
        t_reset();
        final_report();
    end
endmodule
